// *** logic/timer_pkg.sv ***
// How it works
// [R1] Readable, writable 8-bit count at file 01h
// [R2] Clock source clear: count each instruction cycle
// [R3] Count write blocks counting two cycles
// [R4] Clock source set: count external input edges
// [R5] Edge select: clear rising, set falling
// [R6] Assign bit: clear timer, set watchdog
// [R7] One prescaler; unassigned side runs undivided
// [R8] Timer ratios 1:2 up to 1:256
// [R9] Prescaler count has no software access
// [R10] Timer count write clears timer-owned prescaler
// [R11] Watchdog clear clears watchdog-owned prescaler
// [R12] Reset leaves prescaler at zero
// [R13] Prescaler output sampled on phases two, four
// [R14] External input divided before phase sampling
// [R15] Source keeps input pulse widths, period
// [R16] Count changes 3 to 7 Tosc after edge
// [R17] Software sequence for timer to watchdog
// [R18] Software sequence for watchdog to timer
// [R19] Timer divides 2^(n+1), watchdog 2^n
// [R20] Count wraps from maximum to zero
`default_nettype none

package timer_pkg;

  // ------------------------------------------------------------
  // Map and reset values
  // ------------------------------------------------------------
  localparam int PRESCALE_WIDTH = 8;
  localparam logic [4:0] TIMER_COUNT_ADDR = 5'h01;
  localparam logic [7:0] TIMER_COUNT_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h3f;
  localparam logic [7:0] OPTION_WRITE_MASK = 8'h3f;
  localparam logic [7:0] PRESCALER_RESET = 8'h00;
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TOSC_NS = 8;
  localparam int INC_DELAY_MIN_TOSC = 3;
  localparam int INC_DELAY_MAX_TOSC = 7;
  localparam int INC_DELAY_MIN_CYC = (INC_DELAY_MIN_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INC_DELAY_MAX_CYC = (INC_DELAY_MAX_TOSC * TOSC_NS) / CLK_PERIOD_NS;
  // Pin to settled level inside the synchroniser
  localparam int SYNC_LATENCY_CYC = 4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] unused;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } option_t;

  typedef struct packed {
    logic write;
    logic [4:0] addr;
    logic [7:0] data;
  } file_write_t;

  typedef enum logic [3:0] {
    PHASE_ONE = 4'h1,
    PHASE_TWO = 4'h2,
    PHASE_THREE = 4'h4,
    PHASE_FOUR = 4'h8
  } phase_t;

endpackage : timer_pkg

`default_nettype wire

// *** logic/input_sync.sv ***
`default_nettype none

module input_sync (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Stage one is read only by stage two
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= (stage2 == stage3) && stage3 && !level_o;
      fall_o <= (stage2 == stage3) && !stage3 && level_o;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end

endmodule : input_sync

`default_nettype wire

// *** logic/prescale_counter.sv ***
`default_nettype none

module prescale_counter
  import timer_pkg::*;
#(
  parameter int WIDTH = PRESCALE_WIDTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic step_i,
  output logic [WIDTH-1:0] count_o
);

  // Clear wins over a step in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // [R12] zero on reset
      count_o <= WIDTH'(PRESCALER_RESET);
    end else if (clear_i) begin
      count_o <= '0;
    end else if (step_i) begin
      count_o <= count_o + WIDTH'(1);
    end
  end

endmodule : prescale_counter

`default_nettype wire

// *** logic/timer_counter.sv ***
`default_nettype none

module timer_counter
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire file_write_t file_wr_i,
  input wire logic [4:0] file_raddr_i,
  input wire logic option_write_i,
  input wire logic [7:0] option_wdata_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic watchdog_raw_tick_i,
  input wire logic external_count_input_i,
  output logic [7:0] file_rdata_o,
  output logic [7:0] timer_count_o,
  output option_t option_o,
  output logic watchdog_tick_o,
  output phase_t phase_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int INC_LAT_MIN = 1;
  localparam int INC_LAT_MAX = INC_DELAY_MAX_CYC - SYNC_LATENCY_CYC - 1;

  phase_t phase;
  option_t option;
  logic [7:0] timer_count;
  logic [7:0] read_data;
  logic [1:0] inhibit;
  logic [PRESCALE_WIDTH-1:0] prescaler;
  logic [7:0] wd_mask;
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic sampled;
  logic wd_tick;
  logic write_timer;
  logic psc_on_timer;
  logic sample_phase;
  logic src_level;
  logic count_event;
  logic timer_inc;
  logic psc_step;
  logic psc_clear;

  assign file_rdata_o = read_data;
  assign timer_count_o = timer_count;
  assign option_o = option;
  assign watchdog_tick_o = wd_tick;
  assign phase_o = phase;

  // ------------------------------------------------------------
  // Four-phase instruction clock
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase <= PHASE_ONE;
    end else begin
      unique case (phase)
        PHASE_ONE: phase <= PHASE_TWO;
        PHASE_TWO: phase <= PHASE_THREE;
        PHASE_THREE: phase <= PHASE_FOUR;
        PHASE_FOUR: phase <= PHASE_ONE;
        default: phase <= PHASE_ONE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Option register
  // ------------------------------------------------------------
  // [R6] assignment bit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      option <= option_t'(OPTION_RESET);
    end else if (option_write_i) begin
      option <= option_t'(option_wdata_i & OPTION_WRITE_MASK);
    end
  end

  // ------------------------------------------------------------
  // External input
  // ------------------------------------------------------------
  input_sync u_input_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(external_count_input_i),
    .level_o(ext_level),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  // [R5] counting edge
  assign ext_edge = option.source_edge_select ? ext_fall : ext_rise;

  // ------------------------------------------------------------
  // Shared prescaler
  // ------------------------------------------------------------
  assign psc_on_timer = !option.prescaler_assign;
  assign write_timer = file_wr_i.write && (file_wr_i.addr == TIMER_COUNT_ADDR);

  // [R7] one owner at a time
  always_comb begin
    if (!psc_on_timer) begin
      psc_step = watchdog_raw_tick_i;
    end else if (option.clock_source_select) begin
      // [R14] divide input edges first
      psc_step = ext_edge;
    end else begin
      psc_step = (phase == PHASE_FOUR);
    end
  end

  // [R10] count write clears it
  // [R11] watchdog clear clears it
  assign psc_clear = (write_timer && psc_on_timer) || (watchdog_clear_instr_i && !psc_on_timer);

  // [R9] count is internal only
  prescale_counter #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescale_counter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(psc_clear),
    .step_i(psc_step),
    .count_o(prescaler)
  );

  // ------------------------------------------------------------
  // Watchdog side
  // ------------------------------------------------------------
  // [R19] watchdog divides by 2^n
  assign wd_mask = 8'((9'h001 << option.prescale_ratio) - 9'h001);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_tick <= 1'b0;
    end else if (psc_on_timer) begin
      // [R7] undivided when not owner
      wd_tick <= watchdog_raw_tick_i;
    end else begin
      wd_tick <= watchdog_raw_tick_i && ((prescaler & wd_mask) == wd_mask);
    end
  end

  // ------------------------------------------------------------
  // Count source and phase sampling
  // ------------------------------------------------------------
  assign sample_phase = (phase == PHASE_TWO) || (phase == PHASE_FOUR);

  // [R8] bit n toggles every 2^n steps
  // [R19] timer divides by 2^(n+1)
  assign src_level = psc_on_timer ? prescaler[option.prescale_ratio] : (ext_level ^ option.source_edge_select);

  // [R13] sample on phases two and four
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sampled <= 1'b0;
    end else if (sample_phase) begin
      sampled <= src_level;
    end
  end

  always_comb begin
    if (!option.clock_source_select && !psc_on_timer) begin
      // [R2] once per instruction cycle
      count_event = (phase == PHASE_FOUR);
    end else begin
      // [R4] external or divided source
      count_event = sample_phase && src_level && !sampled;
    end
  end

  // ------------------------------------------------------------
  // Write inhibit
  // ------------------------------------------------------------
  // Software can pre-adjust the written value to hide this gap
  // [R3] two-cycle hold-off
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      inhibit <= 2'h0;
    end else if (write_timer) begin
      inhibit <= WRITE_INHIBIT_CYCLES;
    end else if ((phase == PHASE_FOUR) && (inhibit != 2'h0)) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  assign timer_inc = count_event && (inhibit == 2'h0);

  // ------------------------------------------------------------
  // Count register and read path
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_count <= TIMER_COUNT_RESET;
    end else if (write_timer) begin
      // [R1] software load
      timer_count <= file_wr_i.data;
    end else if (timer_inc) begin
      // [R20] wraps, no flag
      timer_count <= timer_count + 8'h01;
    end
  end

  // Only the count is readable; other files belong elsewhere
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      read_data <= 8'h00;
    end else begin
      // [R1] read path
      read_data <= (file_raddr_i == TIMER_COUNT_ADDR) ? timer_count : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence seq_q4_write;
    write_timer && (phase == PHASE_FOUR);
  endsequence

  sequence seq_hold_two_cycles;
    (!write_timer) [*8];
  endsequence

  a_write_loads: assert property (write_timer |=> timer_count == $past(file_wr_i.data)) // [R1]
    else $error("count write not loaded");

  a_read_returns: assert property ((file_raddr_i == TIMER_COUNT_ADDR) |=> read_data == $past(timer_count)) // [R1]
    else $error("count read wrong");

  a_write_inhibit: assert property (seq_q4_write |=> inhibit == WRITE_INHIBIT_CYCLES) // [R3]
    else $error("inhibit not armed by count write");

  a_inhibit_holds: assert property (seq_q4_write ##1 seq_hold_two_cycles |-> timer_count == $past(timer_count, 7)) // [R3]
    else $error("count moved during write hold-off");

  a_timer_step: assert property ((count_event && !option.clock_source_select && psc_on_timer == 1'b0 &&
      inhibit == 2'h0 && !write_timer) |=> timer_count == $past(timer_count) + 8'h01) // [R2]
    else $error("timer mode step missing");

  a_edge_counts: assert property ((ext_edge && option.clock_source_select && !psc_on_timer &&
      inhibit == 2'h0 && !write_timer) |-> ##[INC_LAT_MIN:INC_LAT_MAX] $changed(timer_count)) // [R16]
    else $error("external edge not counted in time");

  a_clear_on_write: assert property ((write_timer && psc_on_timer) |=> prescaler == '0) // [R10]
    else $error("prescaler not cleared by count write");

  a_clear_on_wdt: assert property ((watchdog_clear_instr_i && !psc_on_timer) |=> prescaler == '0) // [R11]
    else $error("prescaler not cleared by watchdog clear");

  a_wd_undivided: assert property ((psc_on_timer && watchdog_raw_tick_i) |=> wd_tick) // [R7]
    else $error("watchdog divided while prescaler on timer");

  a_wd_divided: assert property ((wd_tick && !$past(psc_on_timer)) |->
      ($past(prescaler) & $past(wd_mask)) == $past(wd_mask)) // [R19]
    else $error("watchdog tick at wrong ratio");

  a_no_idle_step: assert property ((!count_event && !write_timer) |=> $stable(timer_count)) // [R4]
    else $error("count moved without event");

endmodule : timer_counter

`default_nettype wire

// *** bench/count_source.sv ***
`default_nettype none

module count_source (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic go_i,
  input wire logic [7:0] pulses_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Pulse train on the count pin
  // ----------------------------------------
  int left = 0;
  int ph = 0;
  initial pin_o = 1'h0;
  always @(posedge clk_i) begin
    if (go_i) begin
      left = 2 * pulses_i;
      ph = 0;
    end else if (left > 0 && ++ph == 3) begin
      ph = 0;
      left--;
    end
    pin_o <= #2 hold_i | left[0];
  end
endmodule : count_source

`default_nettype wire

// *** bench/timer_counter_tb_top.sv ***
`default_nettype none

module timer_counter_tb_top
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic opt_w = 1'h0, wdc = 1'h0, raw = 1'h0, hold = 1'h0, go = 1'h0, rd_v = 1'h0, rd_d = 1'h0, pin;
  logic [4:0] raddr = 5'h00;
  logic [7:0] opt_d = 8'h00, pulses = 8'h00, rdata, count, d;
  file_write_t fw = '0;
  option_t opt;
  logic wd_tick;
  phase_t phase;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'haa14;
  int bad_count = 0, total_checks = 0, wd_cnt = 0;

  always #4 clk_i = ~clk_i;

  count_source src (.clk_i(clk_i), .hold_i(hold), .go_i(go), .pulses_i(pulses), .pin_o(pin));
  timer_counter DUT (.clk_i(clk_i), .reset_i(reset_i), .file_wr_i(fw), .file_raddr_i(raddr),
    .option_write_i(opt_w), .option_wdata_i(opt_d), .watchdog_clear_instr_i(wdc),
    .watchdog_raw_tick_i(raw), .external_count_input_i(pin), .file_rdata_o(rdata),
    .timer_count_o(count), .option_o(opt), .watchdog_tick_o(wd_tick), .phase_o(phase));

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    raddr = a;
    rd_v = 1'h1;
    exp_q.push_back(e);
    tick(1);
    rd_v = 1'h0;
  endtask : rd

  task automatic wr(input logic [7:0] v);
    fw = '{1'h1, TIMER_COUNT_ADDR, v};
    tick(1);
    fw.write = 1'h0;
  endtask : wr

  task automatic setopt(input logic [7:0] v);
    opt_w = 1'h1;
    opt_d = v;
    tick(1);
    opt_w = 1'h0;
  endtask : setopt

  task automatic wclr();
    wdc = 1'h1;
    tick(1);
    wdc = 1'h0;
  endtask : wclr

  // clear watchdog and count before option
  task automatic sw(input logic [7:0] v);
    wclr();
    wr(8'h00);
    if (v[3] && v[2:1] == 2'h0) begin
      setopt(8'h0f);
      wclr();
    end
    setopt(v);
  endtask : sw

  task automatic ext(input logic [7:0] n, input logic [7:0] e);
    // Let the write hold-off run out before the first pin edge
    tick(12);
    pulses = n;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(6 * n + 12);
    rd(TIMER_COUNT_ADDR, e);
  endtask : ext

  task automatic wd(input int t, input logic [7:0] e);
    wclr();
    wd_cnt = 0;
    repeat (t) begin
      raw = 1'h1;
      tick(1);
      raw = 1'h0;
      tick(1);
    end
    tick(3);
    check(8'(wd_cnt), e);
  endtask : wd

  // Read results come back one cycle after the address is taken; sampled mid-cycle where settled
  always @(negedge clk_i) begin
    if (rd_d) check(rdata, exp_q.pop_front());
    rd_d <= rd_v;
    if (wd_tick === 1'h1) wd_cnt++;
  end

  // Tests need about 6000 cycles; this limit leaves a wide margin
  initial begin
    #200us;
    bad_count++;
    finish_test();
  end

  initial begin
    tick(2);
    reset_i = 1'h0;
    check(count, TIMER_COUNT_RESET);
    check(opt, OPTION_RESET);
    rd(TIMER_COUNT_ADDR, 8'h00);
    d = rnd();
    setopt(d);
    check(opt, d & OPTION_WRITE_MASK);
    repeat (4) rd(5'(rnd() | 8'h02), 8'h00);
    $display("register tests done");
    sw(8'h08);
    for (int k = 1; k < 5; k++) begin
      d = (k > 2) ? 8'hfe : rnd();
      do tick(1); while (phase !== PHASE_TWO);
      wr(d);
      tick(4 * k + 2);
      rd(TIMER_COUNT_ADDR, d + 8'(k - 1));
    end
    for (int r = 2; r < 8; r++) begin
      sw(8'(r));
      d = rnd();
      wr(d);
      tick((16 << r) + 1);
      rd(TIMER_COUNT_ADDR, d + 8'h02);
    end
    $display("timer tests done");
    sw(8'h28);
    d = (rnd() & 8'h07) + 8'h01;
    wr(8'h10);
    ext(d, 8'h10 + d);
    sw(8'h22);
    wr(8'h40);
    ext(8'h10, 8'h42);
    sw(8'h38);
    wr(8'h20);
    hold = 1'h1;
    tick(12);
    check(count, 8'h20);
    hold = 1'h0;
    tick(3);
    check(count, 8'h20);
    tick(5);
    check(count, 8'h21);
    $display("counter tests done");
    for (int r = 0; r < 8; r++) begin
      sw(8'h08 | 8'(r));
      wd(3 << r, 8'h03);
    end
    sw(8'h05);
    wd(5, 8'h05);
    sw(8'h0a);
    wd(3, 8'h00);
    wd(3, 8'h00);
    $display("watchdog tests done");
    finish_test();
  end
endmodule : timer_counter_tb_top

`default_nettype wire
